/* File: data_space_and_eeprom_access_bench.sv */
// testbench: data space map, pointer modes and nv port sequences
`timescale 1ns/1ps
`define CK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("mismatch %0t %h %h", $time, (a), (b)); end end
module data_space_and_eeprom_access_bench;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  localparam logic [5:0] CT = dsea_pkg::IO_NV_CTRL;
  localparam logic [5:0] DT = dsea_pkg::IO_NV_DATA;
  localparam logic [5:0] AL = dsea_pkg::IO_NV_ADDR_LO;
  localparam logic [5:0] AH = dsea_pkg::IO_NV_ADDR_HI;
  logic i_clk_sys = 1'b0;
  logic i_reset = 1'b1;
  dsea_pkg::dsea_req_t req = '0;
  logic [7:0] rd, rdata, rfwd, rfd, ioa, iowd, iod;
  logic ack, stall, fault, rfwe, pwe, iowe, iore, flt;
  logic [4:0] rfa, pa;
  logic [15:0] pval, px, py, pz;
  int errors = 0;
  int checks = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  dsea_core #(.WRITE_CYCLES(20)) dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(req),
    .o_rdata(rdata), .o_ack(ack), .o_stall(stall), .o_fault(fault), .o_regfile_we(rfwe),
    .o_regfile_addr(rfa), .o_regfile_wdata(rfwd), .o_ptr_we(pwe), .o_ptr_addr(pa),
    .o_ptr_value(pval), .o_io_we(iowe), .o_io_re(iore), .o_io_addr(ioa), .o_io_wdata(iowd),
    .i_io_rdata(iod), .i_regfile_rdata(rfd), .i_ptr_x(px), .i_ptr_y(py), .i_ptr_z(pz));
  dsea_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_rf_we(rfwe), .i_rf_addr(rfa), .i_rf_wdata(rfwd),
    .i_ptr_we(pwe), .i_ptr_addr(pa), .i_ptr_value(pval), .i_io_we(iowe), .i_io_re(iore),
    .i_io_addr(ioa), .i_io_wdata(iowd), .o_rf_rdata(rfd), .o_io_rdata(iod), .o_px(px),
    .o_py(py), .o_pz(pz));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  function automatic dsea_pkg::dsea_req_t mk(input logic w, s, input logic [5:0] io,
    input logic [1:0] m, sl, input logic [15:0] a, input logic [5:0] d, input logic [7:0] v);
    return '{1'b1, w, s, io, dsea_pkg::dsea_amode_t'(m), sl, a, d, v};
  endfunction
  task automatic go(input dsea_pkg::dsea_req_t r);
    int n;
    @(negedge i_clk_sys);
    req = r;
    #1 flt = fault;
    @(negedge i_clk_sys);
    req = '0;
    n = 0;
    while (ack !== 1'b1 && n < 4)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    `CK(ack, 1'b1)
    rd = rdata;
    repeat (2) @(negedge i_clk_sys);
    n = 0;
    while (stall !== 1'b0 && n < 8)
    begin
      @(negedge i_clk_sys);
      n++;
    end
    `CK(stall, 1'b0)
  endtask
  task dw(input logic [15:0] a, input logic [7:0] v); go(mk(1, 0, 0, 0, 0, a, 0, v)); endtask
  task drd(input logic [15:0] a); go(mk(0, 0, 0, 0, 0, a, 0, 0)); endtask
  task iw(input logic [5:0] a, input logic [7:0] v); go(mk(1, 1, a, 0, 0, 0, 0, v)); endtask
  task ir(input logic [5:0] a); go(mk(0, 1, a, 0, 0, 0, 0, 0)); endtask
  // arm, then strobe after g+1 idle cycles
  task automatic wseq(input int g);
    @(negedge i_clk_sys);
    req = mk(1, 1, CT, 0, 0, 0, 0, 8'h04);
    @(negedge i_clk_sys);
    req = '0;
    repeat (g) @(negedge i_clk_sys);
    go(mk(1, 1, CT, 0, 0, 0, 0, 8'h02));
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_map;
    dw(16'h001F, 8'h3C);
    drd(16'h001F); `CK(rd, 8'h3C)
    drd(16'h0020); `CK(rd, 8'h00 ^ 8'h5A)
    drd(16'h00FF); `CK(rd, 8'hDF ^ 8'h5A)
    ir(6'h01); `CK(rd, 8'h01 ^ 8'h5A)
    iw(6'h05, 8'hC3);
    ir(6'h05); `CK(rd, 8'hC3)
    dw(16'h0080, 8'h3A);
    drd(16'h0080); `CK(rd, 8'h3A)
    dw(16'h0100, 8'h11);
    dw(16'h04FF, 8'h22);
    drd(16'h0100); `CK(rd, 8'h11)
    drd(16'h04FF); `CK(rd, 8'h22)
    drd(16'h0500); `CK(flt, 1'b1)
  endtask
  task t_ptr;
    dw(16'h001C, 8'h00);
    dw(16'h001D, 8'h01);
    go(mk(1, 0, 0, 1, 1, 0, 6'h3F, 8'h77));
    drd(16'h013F); `CK(rd, 8'h77)
    dw(16'h001A, 8'h00);
    dw(16'h001B, 8'h02);
    go(mk(1, 0, 0, 3, 0, 0, 0, 8'h44));
    drd(16'h0200); `CK(rd, 8'h44)
    drd(16'h001A); `CK(rd, 8'h01)
    dw(16'h001E, 8'h00);
    dw(16'h001F, 8'h03);
    go(mk(1, 0, 0, 2, 2, 0, 0, 8'h55));
    drd(16'h02FF); `CK(rd, 8'h55)
    drd(16'h001F); `CK(rd, 8'h02)
  endtask
  task t_nv;
    int n;
    iw(AH, 8'hFF);
    iw(AL, 8'h23);
    ir(AH); `CK(rd, 8'h01)
    iw(AH, 8'h00);
    ir(AH); `CK(rd, 8'h00)
    iw(DT, 8'hA5);
    wseq(0);
    ir(CT); `CK(rd[1], 1'b1)
    iw(AL, 8'h99);
    iw(DT, 8'h5C);
    iw(CT, 8'h01);
    ir(DT); `CK(rd, 8'h5C)
    n = 0;
    ir(CT);
    while (rd[1] !== 1'b0 && n < 40)
    begin
      ir(CT);
      n++;
    end
    `CK(rd[1], 1'b0)
    ir(AL); `CK(rd, 8'h23)
    iw(DT, 8'h00);
    iw(CT, 8'h01);
    ir(DT); `CK(rd, 8'hA5)
    iw(DT, 8'h3C);
    iw(CT, 8'h02);
    ir(CT); `CK(rd[1], 1'b0)
    wseq(4);
    ir(CT); `CK(rd[1], 1'b0)
    iw(CT, 8'h01);
    ir(DT); `CK(rd, 8'hA5)
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task end_of_test;
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(negedge i_clk_sys);
    i_reset = 1'b0;
    t_map;
    t_ptr;
    t_nv;
    end_of_test;
  end
  // about twenty thousand cycles, far beyond the expected run
  initial
  begin
    #800000;
    errors++;
    end_of_test;
  end
endmodule // data_space_and_eeprom_access_bench

/* File: dsea_core.sv */
// data space decoder and nonvolatile byte access port
`timescale 1ns/1ps
module dsea_core #(
  parameter int WRITE_CYCLES = dsea_pkg::WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire dsea_pkg::dsea_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_ack,
  output logic o_stall,
  output logic o_fault,
  output logic o_regfile_we,
  output logic [4:0] o_regfile_addr,
  output logic [7:0] o_regfile_wdata,
  output logic o_ptr_we,
  output logic [4:0] o_ptr_addr,
  output logic [15:0] o_ptr_value,
  output logic o_io_we,
  output logic o_io_re,
  output logic [7:0] o_io_addr,
  output logic [7:0] o_io_wdata,
  input wire logic [7:0] i_io_rdata,
  input wire logic [7:0] i_regfile_rdata,
  input wire logic [15:0] i_ptr_x,
  input wire logic [15:0] i_ptr_y,
  input wire logic [15:0] i_ptr_z
);
  // -------------------------------------------------------
  // effective address
  // -------------------------------------------------------
  logic [15:0] ptr_sel_val;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  logic [15:0] eff_addr;
  logic [4:0] ptr_lo_idx;
  logic [5:0] disp_clip;
  assign ptr_sel_val = (i_req.ptr_sel == 2'h0) ? i_ptr_x :
                       (i_req.ptr_sel == 2'h1) ? i_ptr_y : i_ptr_z;
  assign ptr_lo_idx = (i_req.ptr_sel == 2'h0) ? dsea_pkg::PTR_X_LO :
                      (i_req.ptr_sel == 2'h1) ? dsea_pkg::PTR_Y_LO : dsea_pkg::PTR_Z_LO;
  assign ptr_dec = ptr_sel_val - 16'h0001;
  assign ptr_inc = ptr_sel_val + 16'h0001;
  assign disp_clip = i_req.disp & dsea_pkg::DISP_MAX;
  always_comb
  begin
    unique case (i_req.mode)
      dsea_pkg::DSEA_AM_DIRECT: eff_addr = i_req.direct_addr;
      dsea_pkg::DSEA_AM_DISP: eff_addr = ptr_sel_val + {10'h000, disp_clip};
      dsea_pkg::DSEA_AM_PREDEC: eff_addr = ptr_dec;
      dsea_pkg::DSEA_AM_POSTINC: eff_addr = ptr_sel_val;
    endcase
  end
  // -------------------------------------------------------
  // region decode
  // -------------------------------------------------------
  dsea_pkg::dsea_region_t region;
  logic [15:0] space_addr;
  assign space_addr = i_req.short_io ? (dsea_pkg::STDIO_BASE + {10'h000, i_req.io_addr})
                                     : eff_addr;
  always_comb
  begin
    if (space_addr <= dsea_pkg::REGFILE_TOP)
      region = dsea_pkg::DSEA_RGN_REG;
    else if (space_addr <= dsea_pkg::STDIO_TOP)
      region = dsea_pkg::DSEA_RGN_STDIO;
    else if (space_addr <= dsea_pkg::EXTIO_TOP)
      region = dsea_pkg::DSEA_RGN_EXTIO;
    else if (space_addr <= dsea_pkg::SRAM_TOP)
      region = dsea_pkg::DSEA_RGN_SRAM;
    else
      region = dsea_pkg::DSEA_RGN_NONE;
  end
  logic [7:0] io_idx;
  logic [5:0] std_idx;
  logic hit_reg;
  logic hit_io;
  logic hit_sram;
  logic hit_nv;
  logic go;
  assign go = i_req.valid & ~o_stall;
  assign io_idx = 8'(space_addr - dsea_pkg::STDIO_BASE);
  assign std_idx = io_idx[5:0];
  assign hit_reg = go & (region == dsea_pkg::DSEA_RGN_REG);
  assign hit_io = go & ((region == dsea_pkg::DSEA_RGN_STDIO) |
                  (region == dsea_pkg::DSEA_RGN_EXTIO));
  assign hit_sram = go & (region == dsea_pkg::DSEA_RGN_SRAM);
  assign hit_nv = go & (region == dsea_pkg::DSEA_RGN_STDIO) &
                  ((std_idx == dsea_pkg::IO_NV_CTRL) | (std_idx == dsea_pkg::IO_NV_DATA) |
                   (std_idx == dsea_pkg::IO_NV_ADDR_LO) | (std_idx == dsea_pkg::IO_NV_ADDR_HI));
  // -------------------------------------------------------
  // pointer update and register file path
  // -------------------------------------------------------
  assign o_ptr_we = go & ~i_req.short_io & ((i_req.mode == dsea_pkg::DSEA_AM_PREDEC) |
                    (i_req.mode == dsea_pkg::DSEA_AM_POSTINC));
  assign o_ptr_addr = ptr_lo_idx;
  assign o_ptr_value = (i_req.mode == dsea_pkg::DSEA_AM_PREDEC) ? ptr_dec : ptr_inc;
  assign o_regfile_we = hit_reg & i_req.write;
  assign o_regfile_addr = space_addr[4:0];
  assign o_regfile_wdata = i_req.wdata;
  assign o_io_we = hit_io & ~hit_nv & i_req.write;
  assign o_io_re = hit_io & ~hit_nv & ~i_req.write;
  assign o_io_addr = io_idx;
  assign o_io_wdata = i_req.wdata;
  assign o_fault = go & (region == dsea_pkg::DSEA_RGN_NONE);
  // -------------------------------------------------------
  // sram
  // -------------------------------------------------------
  logic [7:0] sram_rdata;
  logic sram_done;
  logic sram_pend_ff;
  logic [dsea_pkg::SRAM_AW-1:0] sram_addr;
  assign sram_addr = dsea_pkg::SRAM_AW'(space_addr - dsea_pkg::SRAM_BASE);
  dsea_sram u_sram (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_req(hit_sram),
    .i_write(i_req.write),
    .i_addr(sram_addr),
    .i_wdata(i_req.wdata),
    .o_rdata(sram_rdata),
    .o_done(sram_done)
  );
  // -------------------------------------------------------
  // nonvolatile port registers
  // -------------------------------------------------------
  logic [dsea_pkg::NV_AW-1:0] nv_byte_address_ff;
  logic [7:0] nv_byte_value_ff;
  logic [2:0] arm_cnt_ff;
  logic [2:0] stall_cnt_ff;
  logic nv_busy;
  logic [7:0] nv_rdata;
  logic wr_ctrl;
  logic nv_write_arm;
  logic nv_write_strobe;
  logic nv_read_strobe;
  logic nv_start;
  logic nv_read;
  logic [2:0] nxt_arm_cnt;
  logic [2:0] nxt_stall_cnt;
  logic [7:0] nv_ctrl_rd;
  assign wr_ctrl = hit_nv & i_req.write & (std_idx == dsea_pkg::IO_NV_CTRL);
  assign nv_write_arm = arm_cnt_ff != 3'h0;
  assign nv_write_strobe = nv_busy;
  assign nv_start = wr_ctrl & i_req.wdata[dsea_pkg::CTRL_WRITE_BIT] &
                    nv_write_arm & ~nv_busy;
  assign nv_read_strobe = wr_ctrl & i_req.wdata[dsea_pkg::CTRL_READ_BIT];
  assign nv_read = nv_read_strobe & ~nv_busy;
  assign nxt_arm_cnt = (wr_ctrl & i_req.wdata[dsea_pkg::CTRL_ARM_BIT] &
                        ~i_req.wdata[dsea_pkg::CTRL_WRITE_BIT]) ? dsea_pkg::ARM_CYCLES :
                       (nv_start ? 3'h0 : (nv_write_arm ? arm_cnt_ff - 3'h1 : 3'h0));
  assign nxt_stall_cnt = nv_read ? dsea_pkg::READ_STALL :
                         nv_start ? dsea_pkg::WRITE_STALL :
                         (stall_cnt_ff != 3'h0 ? stall_cnt_ff - 3'h1 : 3'h0);
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      arm_cnt_ff <= 3'h0;
      stall_cnt_ff <= 3'h0;
    end
    else
    begin
      arm_cnt_ff <= nxt_arm_cnt;
      stall_cnt_ff <= nxt_stall_cnt;
    end
  end
  // address and data have no reset: contents are undefined until written
  always_ff @(posedge i_clk_sys)
  begin
    if (hit_nv && i_req.write && !nv_busy && std_idx == dsea_pkg::IO_NV_ADDR_LO)
      nv_byte_address_ff[7:0] <= i_req.wdata;
    if (hit_nv && i_req.write && !nv_busy && std_idx == dsea_pkg::IO_NV_ADDR_HI)
      nv_byte_address_ff[8] <= i_req.wdata[0];
    if (nv_read)
      nv_byte_value_ff <= nv_rdata;
    else if (hit_nv && i_req.write && std_idx == dsea_pkg::IO_NV_DATA)
      nv_byte_value_ff <= i_req.wdata;
  end
  assign o_stall = stall_cnt_ff != 3'h0;
  dsea_nvmem #(
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_nvmem (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_start(nv_start),
    .i_addr(nv_byte_address_ff),
    .i_wdata(nv_byte_value_ff),
    .o_rdata(nv_rdata),
    .o_busy(nv_busy)
  );
  assign nv_ctrl_rd = {5'h00, nv_write_arm, nv_write_strobe, 1'b0};
  // -------------------------------------------------------
  // read data return
  // -------------------------------------------------------
  logic [7:0] nv_rd_mux;
  logic [7:0] rdata_ff;
  logic ack_ff;
  logic [7:0] nxt_rdata;
  logic nxt_ack;
  always_comb
  begin
    unique case (std_idx)
      dsea_pkg::IO_NV_CTRL: nv_rd_mux = nv_ctrl_rd;
      dsea_pkg::IO_NV_DATA: nv_rd_mux = nv_byte_value_ff;
      dsea_pkg::IO_NV_ADDR_LO: nv_rd_mux = nv_byte_address_ff[7:0];
      dsea_pkg::IO_NV_ADDR_HI: nv_rd_mux = {7'h00, nv_byte_address_ff[8]};
      default: nv_rd_mux = 8'h00;
    endcase
  end
  assign nxt_rdata = sram_done ? sram_rdata :
                     hit_nv ? nv_rd_mux :
                     hit_reg ? i_regfile_rdata :
                     hit_io ? i_io_rdata : 8'h00;
  assign nxt_ack = sram_done | (go & ~hit_sram);
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      rdata_ff <= 8'h00;
      ack_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
    end
  end
  assign o_rdata = rdata_ff;
  assign o_ack = ack_ff;
endmodule // dsea_core

/* File: dsea_core_assertions.sv */
// checker: data space routing, pointer update and nv stall timing
`timescale 1ns/1ps
module dsea_core_chk #(
  parameter int WRITE_CYCLES = 20
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire dsea_pkg::dsea_req_t i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_ack,
  input wire logic o_stall,
  input wire logic o_fault,
  input wire logic o_regfile_we,
  input wire logic [4:0] o_regfile_addr,
  input wire logic [7:0] o_regfile_wdata,
  input wire logic o_ptr_we,
  input wire logic [4:0] o_ptr_addr,
  input wire logic [15:0] o_ptr_value,
  input wire logic o_io_re,
  input wire logic [7:0] o_io_addr,
  input wire logic [7:0] i_regfile_rdata,
  input wire logic [15:0] i_ptr_x,
  input wire logic [15:0] i_ptr_y,
  input wire logic [15:0] i_ptr_z
);
  // ----------------------------------------
  // request decode and properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire tk = i_req.valid && !o_stall;
  wire dr = tk && !i_req.short_io && i_req.mode == dsea_pkg::DSEA_AM_DIRECT;
  wire [15:0] da = i_req.direct_addr;
  wire ctl = tk && i_req.short_io && i_req.write && i_req.io_addr == dsea_pkg::IO_NV_CTRL;
  wire [1:0] sl = i_req.ptr_sel;
  wire [15:0] pv = sl == 2'h0 ? i_ptr_x : (sl == 2'h1 ? i_ptr_y : i_ptr_z);
  wire [4:0] pl = sl == 2'h0 ? dsea_pkg::PTR_X_LO :
                  (sl == 2'h1 ? dsea_pkg::PTR_Y_LO : dsea_pkg::PTR_Z_LO);
  sequence s_hold4; o_stall [*4] ##1 !o_stall; endsequence
  sequence s_hold2; o_stall [*2] ##1 !o_stall; endsequence
  property p_rf; dr && i_req.write && da <= dsea_pkg::REGFILE_TOP |->
    o_regfile_we && o_regfile_addr == da[4:0] && o_regfile_wdata == i_req.wdata; endproperty
  property p_rfrd; dr && !i_req.write && da <= dsea_pkg::REGFILE_TOP |->
    ##1 o_ack && o_rdata == $past(i_regfile_rdata); endproperty
  property p_std; dr && !i_req.write && da >= 16'h0020 && da < 16'h003F |->
    o_io_re && o_io_addr == 8'(da - 16'h0020); endproperty
  property p_ext; dr && !i_req.write && da >= 16'h0060 && da <= 16'h00FF |->
    o_io_re && o_io_addr == 8'(da - 16'h0020) && !o_regfile_we; endproperty
  property p_short; tk && i_req.short_io && !i_req.write && i_req.io_addr < 6'h1F |->
    o_io_re && o_io_addr == {2'h0, i_req.io_addr}; endproperty
  property p_sram; dr && da >= dsea_pkg::SRAM_BASE && da <= dsea_pkg::SRAM_TOP |->
    !o_fault ##2 o_ack; endproperty
  property p_flt; dr && da > dsea_pkg::SRAM_TOP |-> o_fault; endproperty
  property p_dec; tk && !i_req.short_io && i_req.mode == dsea_pkg::DSEA_AM_PREDEC |->
    o_ptr_we && o_ptr_addr == pl && o_ptr_value == pv - 16'h0001; endproperty
  property p_rst; ctl && i_req.wdata == 8'h01 |-> ##1 (!o_stall or s_hold4); endproperty
  property p_wst; ctl && i_req.wdata == 8'h02 |-> ##1 (!o_stall or s_hold2); endproperty
  a_rf: assert property (p_rf) else $error("regfile write misrouted");
  a_rfrd: assert property (p_rfrd) else $error("regfile read data wrong");
  a_std: assert property (p_std) else $error("standard io misrouted");
  a_ext: assert property (p_ext) else $error("extended io misrouted");
  a_short: assert property (p_short) else $error("short io address wrong");
  a_sram: assert property (p_sram) else $error("sram access not two cycles");
  a_flt: assert property (p_flt) else $error("no fault above sram");
  a_dec: assert property (p_dec) else $error("pointer decrement wrong");
  a_rst: assert property (p_rst) else $error("read stall length wrong");
  a_wst: assert property (p_wst) else $error("write stall length wrong");
endmodule // dsea_core_chk
bind dsea_core dsea_core_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_req(i_req), .o_rdata(o_rdata), .o_ack(o_ack), .o_stall(o_stall),
  .o_fault(o_fault), .o_regfile_we(o_regfile_we), .o_regfile_addr(o_regfile_addr),
  .o_regfile_wdata(o_regfile_wdata), .o_ptr_we(o_ptr_we), .o_ptr_addr(o_ptr_addr),
  .o_ptr_value(o_ptr_value), .o_io_re(o_io_re), .o_io_addr(o_io_addr),
  .i_regfile_rdata(i_regfile_rdata), .i_ptr_x(i_ptr_x), .i_ptr_y(i_ptr_y), .i_ptr_z(i_ptr_z));

/* File: dsea_cpu_model.sv */
// cpu side model: register file, pointers and io registers
`timescale 1ns/1ps
module dsea_cpu_model (
  input wire logic i_clk_sys,
  input wire logic i_rf_we,
  input wire logic [4:0] i_rf_addr,
  input wire logic [7:0] i_rf_wdata,
  input wire logic i_ptr_we,
  input wire logic [4:0] i_ptr_addr,
  input wire logic [15:0] i_ptr_value,
  input wire logic i_io_we,
  input wire logic i_io_re,
  input wire logic [7:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_rf_rdata,
  output logic [7:0] o_io_rdata,
  output logic [15:0] o_px,
  output logic [15:0] o_py,
  output logic [15:0] o_pz
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] rf [32];
  logic [7:0] io [256];
  initial for (int i = 0; i < 256; i++) io[i] = 8'(i) ^ 8'h5A;
  assign o_rf_rdata = rf[i_rf_addr];
  // unselected io bus shows the inverse of the addressed io register, not its value
  assign o_io_rdata = i_io_re ? io[i_io_addr] : ~io[i_io_addr];
  assign o_px = {rf[27], rf[26]};
  assign o_py = {rf[29], rf[28]};
  assign o_pz = {rf[31], rf[30]};
  always @(posedge i_clk_sys)
  begin
    if (i_rf_we) rf[i_rf_addr] <= i_rf_wdata;
    if (i_io_we) io[i_io_addr] <= i_io_wdata;
    if (i_ptr_we) {rf[i_ptr_addr + 5'h01], rf[i_ptr_addr]} <= i_ptr_value;
  end
endmodule // dsea_cpu_model

/* File: dsea_nvmem.sv */
// byte-wide nonvolatile array with self-timed write
`timescale 1ns/1ps
module dsea_nvmem #(
  parameter int WRITE_CYCLES = dsea_pkg::WRITE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [dsea_pkg::NV_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_busy
);
  logic [7:0] cells [dsea_pkg::NV_BYTES];
  logic [23:0] cnt_ff;
  logic [23:0] nxt_cnt;
  // -------------------------------------------------------
  // write timer
  // -------------------------------------------------------
  assign nxt_cnt = i_start ? 24'(WRITE_CYCLES) :
                   (cnt_ff != 24'h000000 ? cnt_ff - 24'h000001 : cnt_ff);
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
      cnt_ff <= 24'h000000;
    else
      cnt_ff <= nxt_cnt;
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_start)
      cells[i_addr] <= i_wdata;
  end
  assign o_busy = cnt_ff != 24'h000000;
  assign o_rdata = cells[i_addr];
endmodule // dsea_nvmem

/* File: dsea_pkg.sv */
// package: data space map, nv register map and timing counts
package dsea_pkg;
  // -------------------------------------------------------
  // data space map
  // -------------------------------------------------------
  localparam logic [15:0] REGFILE_TOP = 16'h001F;
  localparam logic [15:0] STDIO_BASE = 16'h0020;
  localparam logic [15:0] STDIO_TOP = 16'h005F;
  localparam logic [15:0] EXTIO_BASE = 16'h0060;
  localparam logic [15:0] EXTIO_TOP = 16'h00FF;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam logic [15:0] SRAM_TOP = 16'h04FF;
  localparam int SRAM_BYTES = 1024;
  localparam int SRAM_AW = 10;
  localparam int IO_AW = 6;
  localparam logic [5:0] DISP_MAX = 6'h3F;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  // -------------------------------------------------------
  // nv port registers (standard i/o index)
  // -------------------------------------------------------
  localparam logic [5:0] IO_NV_CTRL = 6'h1F;
  localparam logic [5:0] IO_NV_DATA = 6'h20;
  localparam logic [5:0] IO_NV_ADDR_LO = 6'h21;
  localparam logic [5:0] IO_NV_ADDR_HI = 6'h22;
  localparam int CTRL_READ_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_ARM_BIT = 2;
  localparam int NV_BYTES = 512;
  localparam int NV_AW = 9;
  // -------------------------------------------------------
  // timing counts in cpu cycles, clock rate in Hz and nv write time in us
  // -------------------------------------------------------
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] READ_STALL = 3'h4;
  localparam logic [2:0] WRITE_STALL = 3'h2;
  localparam int SRAM_CYCLES = 2;
  localparam int CLK_HZ = 25000000;
  localparam int WRITE_TIME_US = 3400;
  localparam int WRITE_CYCLES = (CLK_HZ / 1000000) * WRITE_TIME_US;
  // -------------------------------------------------------
  // carriers
  // -------------------------------------------------------
  typedef enum logic [2:0] {
    DSEA_RGN_REG, DSEA_RGN_STDIO, DSEA_RGN_EXTIO, DSEA_RGN_SRAM, DSEA_RGN_NONE
  } dsea_region_t;
  typedef enum logic [1:0] {
    DSEA_AM_DIRECT, DSEA_AM_DISP, DSEA_AM_PREDEC, DSEA_AM_POSTINC
  } dsea_amode_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic short_io;
    logic [5:0] io_addr;
    dsea_amode_t mode;
    logic [1:0] ptr_sel;
    logic [15:0] direct_addr;
    logic [5:0] disp;
    logic [7:0] wdata;
  } dsea_req_t;
endpackage

/* File: dsea_sram.sv */
// internal data sram with two cycle access
`timescale 1ns/1ps
module dsea_sram (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [dsea_pkg::SRAM_AW-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_done
);
  logic [7:0] mem [dsea_pkg::SRAM_BYTES];
  logic busy_ff;
  logic [dsea_pkg::SRAM_AW-1:0] addr_ff;
  // -------------------------------------------------------
  // access sequencing
  // -------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_reset)
  begin
    if (i_reset)
    begin
      busy_ff <= 1'b0;
      addr_ff <= '0;
    end
    else
    begin
      busy_ff <= i_req & ~busy_ff;
      addr_ff <= i_addr;
    end
  end
  always_ff @(posedge i_clk_sys)
  begin
    if (i_req && i_write && !busy_ff)
      mem[i_addr] <= i_wdata;
  end
  assign o_done = busy_ff;
  assign o_rdata = mem[addr_ff];
endmodule // dsea_sram
